// file: pkg/pinmux_consts.svh
// register offsets, sub-register indices and reset values of the pin mux
`ifndef PINMUX_CONSTS_SVH
`define PINMUX_CONSTS_SVH
`define PM_OFS_PADDR   8'h00
`define PM_OFS_PCTL    8'h04
`define PM_PORT_LIMIT  8'h20
`define PM_OFS_LED_DRIVER_ENABLE   8'h20
`define PM_OFS_LVLH    8'h24
`define PM_OFS_LVLL    8'h28
`define PM_OFS_STAT    8'h2C
`define PM_SUB_ALT     8'h00
`define PM_SUB_FSLO    8'h01
`define PM_SUB_FSHI    8'h02
`define PM_RST_REG     8'h00
`define PM_RST_ALT_PD  8'h01
`define PM_RST_PA2     8'h04
`define PM_NONSEQ      2'h2
`define PM_HSIZE_WORD  3'h2
`endif

// file: pkg/pinmux_pkg.sv
// types shared by the pin mux and its surroundings
package pinmux_pkg;
  typedef logic [7:0] byte_t;
  // one port's pad drive
  typedef struct packed {
    byte_t o;   // pad output level
    byte_t oe;  // pad output enable
  } pin_drive_s;
  // signals the peripherals offer to the pads
  typedef struct packed {
    logic t0_out;       // timer 0 output
    logic t0_outc;      // timer 0 complementary output
    logic t0_mode_out;  // timer 0 mode uses the complement pin
    logic t1_out;       // timer 1 output
    logic t1_outc;      // timer 1 complementary output
    logic t1_mode_out;  // timer 1 mode uses the complement pin
    logic ser_de;       // serial driver enable
    logic ser_txd;      // serial / infrared transmit line
    logic comp_out;     // comparator output
    logic reset_drive;  // chip pulls the reset pad low
    logic dbg_o;        // debug pad output
    logic dbg_oe;       // debug pad output enable
  } periph_drive_s;
  // pad levels handed to the peripherals
  typedef struct packed {
    logic t0_in;          // timer 0 input
    logic t1_in;          // timer 1 input
    logic ser_cts;        // serial clear to send
    logic ser_rxd;        // serial / infrared receive line
    logic ext_clk;        // external clock input
    logic ext_reset_req;  // reset pad is held low
  } periph_sense_s;
endpackage

// file: hdl/gpio_alternate_function_mux.sv
// gpio alternate function multiplexer with ahb-lite register slave
`include "pinmux_consts.svh"

// What this block does
// (R1) alternate mode hands direction to peripheral
// (R2) two set bits pick multi-function pin role
// (R3) crystal enable frees port A bits 0,1
// (R4) timer mode picks input or complement
// (R5) software sets both set bits first
// (R6) four LED sink levels per pin
// (R7) LED mode, enable and level registers
// (R8) port D bit 0 starts as reset
// (R9) port D bit 0 GPIO is output only
// (R10) small package reset on port A bit 2
// (R11) small package bit 2 reverts at reset
// (R12) debug unlock watched during reset
// (R13) no unlock keeps debug off until reset
// (R14) external clock pin then oscillator select
// (R15) large port A has no set bits
// (R16) large port A timer pins
// (R17) large port A serial pins
// (R18) port B analog roles
// (R19) port C analog, comparator, LED roles
// (R20) per-port address and control registers
// (R21) reserved choice leaves pin hi-Z
// (R22) reset returns GPIO defaults
module gpio_alternate_function_mux
  import pinmux_pkg::*;
(
  input  wire logic                          hclk,          // clock
  input  wire logic                          hresetn,       // reset, low
  input  wire logic                          ce,            // clock enable
  input  wire logic                          hsel,          // slave select
  input  wire logic [31:0]                   haddr,         // address
  input  wire logic [1:0]                    htrans,        // transfer type
  input  wire logic                          hwrite,        // write
  input  wire logic [2:0]                    hsize,         // size
  input  wire logic [31:0]                   hwdata,        // write data
  input  wire logic                          hready,        // bus ready
  output logic [31:0]                        hrdata,        // read data
  output logic                               hreadyout,     // slave ready
  output logic                               hresp,         // always okay
  input  wire logic                          small_pkg,     // 8-pin strap
  input  wire logic                          xtal_enable,   // crystal on
  input  wire logic                          dbg_window,    // reset sequence
  input  wire logic                          dbg_unlock,    // key seen
  input  wire logic [3:0][7:0]               pin_in,        // pad levels
  input  wire logic [3:0][7:0]               gpio_o,        // gpio data
  input  wire logic [3:0][7:0]               gpio_oe,       // gpio direction
  input  wire pinmux_pkg::periph_drive_s     periph,        // peripherals
  output pinmux_pkg::pin_drive_s [3:0]       pins,          // pad drive
  output pinmux_pkg::periph_sense_s          sense,         // to peripherals
  output logic [3:0][7:0]                    analog_sel,    // analog roles
  output logic [7:0]                         led_on,        // LED sink on
  output logic [7:0][1:0]                    led_level,     // sink level
  output logic                               dbg_unlocked   // debug open
);
  import pinmux_pkg::*;

  byte_t        paddr_q [4];  // per-port sub-register pointer
  byte_t        alt_q   [4];  // alternate_mode_enable per port
  byte_t        fslo_q  [4];  // function_set_low_bits per port
  byte_t        fshi_q;       // function_set_high_bits, small port A
  byte_t        led_driver_enable_q;      // led_driver_enable
  byte_t        lvlh_q;       // led_level_upper
  byte_t        lvll_q;       // led_level_lower
  logic         init_q;       // package roles applied after reset
  logic         wr_q;         // write data phase pending
  logic         rd_q;         // read waits one cycle
  byte_t        waddr_q;      // captured offset
  logic         hit_q;        // captured transfer is a word inside the low 64 bytes
  pin_drive_s [3:0] drv_d;    // next pad drive
  periph_sense_s sense_d;     // next peripheral inputs
  logic [3:0][7:0] ana_d;     // next analog selects
  logic [7:0]   led_d;        // next LED enables

  // port and sub-register decode
  function automatic byte_t sub_rd(input logic [1:0] p,
                                   input byte_t idx);
    case (idx)
      `PM_SUB_ALT:  sub_rd = alt_q[p];
      `PM_SUB_FSLO: sub_rd = fslo_q[p];
      `PM_SUB_FSHI: sub_rd = (p == 2'h0) ? fshi_q : 8'h00;
      default:      sub_rd = 8'h00;
    endcase
  endfunction

  // address phase acceptance and decode
  wire        accept = ce && hsel && hready && htrans == `PM_NONSEQ;
  wire        hit    = haddr[31:6] == 26'h0 && hsize == `PM_HSIZE_WORD;
  wire [1:0]  wport  = waddr_q[4:3];
  wire        wsub   = waddr_q < `PM_PORT_LIMIT && waddr_q[2];
  wire        wptr   = waddr_q < `PM_PORT_LIMIT && !waddr_q[2];
  wire byte_t wd     = hwdata[7:0];
  wire byte_t stat   = {5'h00, xtal_enable, small_pkg, dbg_unlocked};
  wire byte_t rsub   = sub_rd(wport, paddr_q[wport]);
  wire byte_t rdat   = !hit_q ? 8'h00 :
                       wptr ? paddr_q[wport] :
                       wsub ? rsub :
                       waddr_q == `PM_OFS_LED_DRIVER_ENABLE ? led_driver_enable_q :
                       waddr_q == `PM_OFS_LVLH  ? lvlh_q :
                       waddr_q == `PM_OFS_LVLL  ? lvll_q :
                       waddr_q == `PM_OFS_STAT  ? stat : 8'h00;
  wire        do_wr  = wr_q && hit_q;

  // bus handshake: writes take no wait, reads take one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      waddr_q   <= `PM_RST_REG;
      hit_q     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      wr_q <= accept && hwrite;
      if (accept) begin
        waddr_q <= haddr[7:0];
        hit_q   <= hit;
      end
      // (R20) read wait state
      if (rd_q) begin
        hrdata    <= {24'h00_0000, rdat};
        hreadyout <= 1'b1;
        rd_q      <= 1'b0;
      end else if (accept && !hwrite) begin
        hreadyout <= 1'b0;
        rd_q      <= 1'b1;
      end
    end
  end

  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // (R22) gpio defaults
      for (int p = 0; p < 4; p++) begin
        paddr_q[p] <= `PM_RST_REG;
        alt_q[p]   <= `PM_RST_REG;
        fslo_q[p]  <= `PM_RST_REG;
      end
      fshi_q  <= `PM_RST_REG;
      led_driver_enable_q <= `PM_RST_REG;
      lvlh_q  <= `PM_RST_REG;
      lvll_q  <= `PM_RST_REG;
      init_q  <= 1'b0;
    end else if (ce) begin
      if (!init_q) begin
        // (R8) reset role on the package's reset pin
        init_q <= 1'b1;
        if (small_pkg) begin
          // (R11) port A bit 2 back to reset role
          alt_q[0] <= `PM_RST_PA2;
          fshi_q   <= `PM_RST_PA2;
        end else begin
          alt_q[3] <= `PM_RST_ALT_PD;
        end
      end else if (do_wr && wptr) begin
        paddr_q[wport] <= wd;
      end else if (do_wr && wsub) begin
        // (R20) control register reaches the sub-register
        case (paddr_q[wport])
          `PM_SUB_ALT:  alt_q[wport] <= wd;
          `PM_SUB_FSLO: fslo_q[wport] <= wd;
          // (R15) only the small port A keeps high set bits
          `PM_SUB_FSHI: if (wport == 2'h0 && small_pkg) fshi_q <= wd;
          default:      ;
        endcase
      end else if (do_wr) begin
        // (R7) LED enable and level registers
        case (waddr_q)
          `PM_OFS_LED_DRIVER_ENABLE: led_driver_enable_q <= wd;
          `PM_OFS_LVLH:  lvlh_q <= wd;
          `PM_OFS_LVLL:  lvll_q <= wd;
          default:       ;
        endcase
      end
    end
  end

  // pin function selection
  always_comb begin
    sense_d = '{ser_cts: 1'b1, ser_rxd: 1'b1, default: 1'b0};
    ana_d   = '0;
    led_d   = '0;
    for (int p = 0; p < 4; p++) begin
      // (R1) gpio direction only where alternate mode is off
      // (R21) alternate pins start hi-Z until a role drives them
      drv_d[p].o  = gpio_o[p] & ~alt_q[p];
      drv_d[p].oe = gpio_oe[p] & ~alt_q[p];
    end
    if (!small_pkg) begin
      // (R4) (R16) timer pins; mode picks input or complement
      if (alt_q[0][0] && periph.t0_mode_out) begin
        drv_d[0].o[0] = periph.t0_outc;
        drv_d[0].oe[0] = 1'b1;
      end else if (alt_q[0][0]) sense_d.t0_in = pin_in[0][0];
      if (alt_q[0][6] && periph.t1_mode_out) begin
        drv_d[0].o[6] = periph.t1_outc;
        drv_d[0].oe[6] = 1'b1;
      end else if (alt_q[0][6]) sense_d.t1_in = pin_in[0][6];
      if (alt_q[0][1]) {drv_d[0].o[1], drv_d[0].oe[1]} = {periph.t0_out, 1'b1};
      if (alt_q[0][7]) {drv_d[0].o[7], drv_d[0].oe[7]} = {periph.t1_out, 1'b1};
      // (R17) serial pins
      if (alt_q[0][2]) {drv_d[0].o[2], drv_d[0].oe[2]} = {periph.ser_de, 1'b1};
      if (alt_q[0][3]) sense_d.ser_cts = pin_in[0][3];
      if (alt_q[0][4]) sense_d.ser_rxd = pin_in[0][4];
      if (alt_q[0][5]) {drv_d[0].o[5], drv_d[0].oe[5]} = {periph.ser_txd, 1'b1};
      for (int i = 0; i < 8; i++) begin
        // (R18) port B analog or external clock
        if (alt_q[1][i] && fslo_q[1][i]) ana_d[1][i] = i < 6;
        else if (alt_q[1][i] && i == 3) sense_d.ext_clk = pin_in[1][3];
        // (R19) port C analog and LED roles, comparator on bit 3
        if (alt_q[2][i] && fslo_q[2][i]) begin
          ana_d[2][i] = i < 3;
          led_d[i] = led_driver_enable_q[i];
        end else if (alt_q[2][i] && i == 3) begin
          drv_d[2].o[3] = periph.comp_out;
          drv_d[2].oe[3] = 1'b1;
        end
      end
      if (alt_q[3][0]) begin
        // (R8) bidirectional reset pin
        drv_d[3].o[0] = 1'b0;
        drv_d[3].oe[0] = periph.reset_drive;
        sense_d.ext_reset_req = !pin_in[3][0];
      end else begin
        // (R9) output only in gpio mode
        drv_d[3].oe[0] = 1'b1;
      end
    end else begin
      drv_d[3:1] = '0;
      // (R2) two set bits pick the role on the small package
      for (int i = 0; i < 6; i++) begin
        if (alt_q[0][i]) begin
          case ({i[2:0], fslo_q[0][i], fshi_q[i]})
            5'b000_00: sense_d.t0_in = pin_in[0][0];
            5'b000_11: {drv_d[0].o[0], drv_d[0].oe[0]} =
                         {periph.t0_outc, 1'b1};
            5'b001_00: {drv_d[0].o[1], drv_d[0].oe[1]} =
                         {periph.t0_out, 1'b1};
            5'b001_10: sense_d.ext_clk = pin_in[0][1];
            5'b010_00: {drv_d[0].o[2], drv_d[0].oe[2]} =
                         {periph.ser_de, 1'b1};
            // (R10) reset role shares port A bit 2
            5'b010_01: begin
              drv_d[0].o[2] = 1'b0;
              drv_d[0].oe[2] = periph.reset_drive;
              sense_d.ext_reset_req = !pin_in[0][2];
            end
            5'b010_10: {drv_d[0].o[2], drv_d[0].oe[2]} =
                         {periph.t1_out, 1'b1};
            5'b011_00: sense_d.ser_cts = pin_in[0][3];
            5'b011_01: {drv_d[0].o[3], drv_d[0].oe[3]} =
                         {periph.comp_out, 1'b1};
            5'b011_10: sense_d.t1_in = pin_in[0][3];
            5'b100_00: sense_d.ser_rxd = pin_in[0][4];
            5'b101_00: {drv_d[0].o[5], drv_d[0].oe[5]} =
                         {periph.ser_txd, 1'b1};
            5'b101_01: {drv_d[0].o[5], drv_d[0].oe[5]} =
                         {periph.t1_outc, 1'b1};
            5'b001_11, 5'b011_11, 5'b100_11, 5'b101_11:
                       ana_d[0][i] = 1'b1;
            default:   ;
          endcase
        end
      end
      // (R12) unlocked debug owns port A bit 0
      if (dbg_unlocked) begin
        drv_d[0].o[0] = periph.dbg_o;
        drv_d[0].oe[0] = periph.dbg_oe;
      end
    end
    // (R3) crystal overrides port A bits 0 and 1
    if (xtal_enable) begin
      drv_d[0].o[1:0] = 2'b00;
      drv_d[0].oe[1:0] = 2'b00;
      ana_d[0][1:0] = 2'b00;
    end
  end

  // registered pad and peripheral outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins         <= '0;
      sense        <= '{ser_cts: 1'b1, ser_rxd: 1'b1, default: 1'b0};
      analog_sel   <= '0;
      led_on       <= 8'h00;
      led_level    <= '0;
      dbg_unlocked <= 1'b0;
    end else if (ce) begin
      pins       <= drv_d;
      sense      <= sense_d;
      analog_sel <= ana_d;
      led_on     <= led_d;
      // (R6) level code per pin, upper bit from the upper register
      for (int i = 0; i < 8; i++) led_level[i] <= {lvlh_q[i], lvll_q[i]};
      // (R13) only the reset window can open debug
      if (small_pkg && dbg_window && dbg_unlock) dbg_unlocked <= 1'b1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_req;
    ce && hsel && hready && htrans == `PM_NONSEQ && !hwrite;
  endsequence
  sequence s_wr_led;
    ce && hsel && hready && htrans == `PM_NONSEQ && hwrite
      && haddr == 32'h0000_0020 && hsize == `PM_HSIZE_WORD ##1 ce;
  endsequence

  property p_rd_wait;
    s_rd_req ##1 ce |-> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong"); // R20
  property p_led_wr;
    s_wr_led ##1 init_q |-> led_driver_enable_q == $past(hwdata[7:0]);
  endproperty
  a_led_wr: assert property (p_led_wr) else $error("led enable lost"); // R7
  property p_xtal;
    ce && xtal_enable |=> pins[0].oe[1:0] == 2'b00;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal pins driven"); // R3
  property p_gpio_dir;
    ce && !small_pkg && !alt_q[1][0] |=> pins[1].oe[0] == $past(gpio_oe[1][0]);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("gpio dir lost"); // R1
  property p_pd_out;
    ce && !small_pkg && init_q && !alt_q[3][0] |=> pins[3].oe[0];
  endproperty
  a_pd_out: assert property (p_pd_out) else $error("pd gpio not out"); // R9
  property p_pd_rst;
    ce && !small_pkg && alt_q[3][0] && !pin_in[3][0] |=> sense.ext_reset_req;
  endproperty
  a_pd_rst: assert property (p_pd_rst) else $error("reset pin ignored"); // R8
  property p_pa2_rst;
    ce && small_pkg && alt_q[0][2] && !fslo_q[0][2] && fshi_q[2]
      && !pin_in[0][2] |=> sense.ext_reset_req;
  endproperty
  a_pa2_rst: assert property (p_pa2_rst) else $error("pa2 reset lost"); // R10
  property p_dbg_hold;
    !(dbg_window && dbg_unlock) |=> $stable(dbg_unlocked);
  endproperty
  a_dbg_hold: assert property (p_dbg_hold) else $error("debug changed"); // R13
  property p_t0c;
    ce && !small_pkg && !xtal_enable && alt_q[0][0] && periph.t0_mode_out
      |=> pins[0].oe[0] && pins[0].o[0] == $past(periph.t0_outc);
  endproperty
  a_t0c: assert property (p_t0c) else $error("timer complement lost"); // R4
  property p_rsvd;
    ce && !small_pkg && alt_q[1][6] |=> !pins[1].oe[6] && !analog_sel[1][6];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved pin driven"); // R21
  property p_clk;
    ce && small_pkg && !xtal_enable && alt_q[0][1] && fslo_q[0][1]
      && !fshi_q[1] |=> sense.ext_clk == $past(pin_in[0][1]);
  endproperty
  a_clk: assert property (p_clk) else $error("clock pin lost"); // R2
endmodule

// file: tb/periph_model.sv
// behavioural model of the on-chip peripherals facing the pin mux
module periph_model
  import pinmux_pkg::*;
(
  input  wire logic                 hclk,     // clock
  input  wire logic                 hresetn,  // reset, low
  input  wire logic                 load,     // take a new pattern
  input  wire logic [11:0]          cfg,      // pattern to present
  output pinmux_pkg::periph_drive_s periph    // drive toward the pads
);
  periph_drive_s nxt_d;  // next drive pattern
  // complements always mirror the true timer outputs, as real timers do
  assign nxt_d = {cfg[11], !cfg[11], cfg[9], cfg[8], !cfg[8], cfg[6:0]};
  // hold each pattern so the bench can predict every pad
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph <= '0;
    end else if (load) begin
      periph <= nxt_d;
    end
  end
endmodule

// file: tb/gpio_alternate_function_mux_tb.sv
// self-checking bench for the gpio alternate function mux
`include "pinmux_consts.svh"
module gpio_alternate_function_mux_tb import pinmux_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic             hclk = 1'b0;        // bus clock
  logic             hresetn = 1'b0;     // reset, low
  logic             hsel = 1'b1;        // single slave
  logic             ce = 1'b1;          // clock enable
  logic             hwrite = 1'b0;      // write strobe
  logic [31:0]      haddr = '0;         // address
  logic [31:0]      hwdata = '0;        // write data
  logic [1:0]       htrans = 2'h0;      // transfer type
  logic [2:0]       hsize = `PM_HSIZE_WORD;  // word only
  logic             small_pkg = 1'b0;   // package strap
  logic             xtal_enable = 1'b0; // crystal override
  logic             dbg_window = 1'b1;  // reset sequence
  logic             dbg_unlock = 1'b0;  // key seen
  logic [3:0][7:0]  pin_in = '0;        // pad levels
  logic [3:0][7:0]  gpio_o = '0;        // gpio data
  logic [3:0][7:0]  gpio_oe = '0;       // gpio direction
  logic [11:0]      cfg = '0;           // peripheral pattern
  logic             load = 1'b0;        // pattern strobe
  logic [31:0]      rs = 32'hDFEA;      // random state
  logic             pend = 1'b0;        // read in data phase
  logic [31:0]      hrdata;             // read data
  logic             hreadyout;          // slave ready
  logic             hresp;              // response
  logic             dbg_unlocked;       // debug open
  logic [3:0][7:0]  analog_sel;         // analog roles
  logic [7:0]       led_on;             // led sinks on
  logic [7:0][1:0]  led_level;          // sink levels
  logic [7:0][1:0]  lv;                 // expected levels
  periph_drive_s    periph;             // peripheral drive
  pin_drive_s [3:0] pins;               // pad drive
  periph_sense_s    sense;              // pad levels inward
  logic [31:0]      exp_q[$];           // expected read data
  int               num_errors = 0;     // mismatches
  int               checks = 0;         // comparisons

  gpio_alternate_function_mux uut (.hclk, .hresetn, .ce, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .small_pkg, .xtal_enable, .dbg_window, .dbg_unlock,
    .pin_in, .gpio_o, .gpio_oe, .periph, .pins, .sense, .analog_sel, .led_on,
    .led_level, .dbg_unlocked);
  periph_model peer (.hclk, .hresetn, .load, .cfg, .periph);

  // free-running 40 MHz clock
  initial begin
    forever #12.5 hclk = ~hclk;
  end

  // xorshift step for repeatable stimulus
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  // pad and flag comparison
  task automatic chk(input string n, input logic [15:0] g,
                     input logic [15:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // read data comparison
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR hrdata expected %h seen %h", e, g);
    end
  endtask

  // watcher: each finished read takes the oldest note off the queue
  always @(posedge hclk) begin
    if (hreadyout === 1'b1) begin
      if (pend) begin
        chk_rd(exp_q.pop_front(), hrdata);
        chk("hresp", hresp, 1'b0);
      end
      pend = htrans === `PM_NONSEQ && hwrite === 1'b0 && hresetn === 1'b1;
    end
  end

  // one single word transfer; a read notes its expected data
  task automatic xfer(input logic wr, input logic [7:0] a, input byte_t d);
    @(posedge hclk);
    htrans <= `PM_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    if (!wr)
      exp_q.push_back({24'h0, d});
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  // sub-register write and read through pointer and control words
  task automatic wsub(input int p, input byte_t i, input byte_t d);
    xfer(1'b1, 8'(8 * p), i);
    xfer(1'b1, 8'(8 * p + 4), d);
  endtask
  task automatic rsub(input int p, input byte_t i, input byte_t e);
    xfer(1'b1, 8'(8 * p), i);
    xfer(1'b0, 8'(8 * p + 4), e);
  endtask

  // reset with the debug key shown or withheld during the window
  task automatic rst(input logic unl);
    hresetn    <= 1'b0;
    dbg_window <= 1'b1;
    dbg_unlock <= unl;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    dbg_window <= 1'b0;
  endtask

  // fresh pad levels, gpio settings and peripheral pattern
  task automatic rnd(input logic t1m, input logic t0m);
    @(posedge hclk);
    rs = xs(rs);
    pin_in <= rs;
    rs = xs(rs);
    gpio_o <= rs;
    rs = xs(rs);
    gpio_oe <= rs;
    cfg  <= {rs[31:30], t0m, rs[29:28], t1m, rs[27:22]};
    load <= 1'b1;
    @(posedge hclk);
    load <= 1'b0;
  endtask

  // let registered outputs land, then sample off the edge
  task automatic settle;
    repeat (3) @(posedge hclk);
    #1;
  endtask

  task automatic conclude;
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    conclude();
  end

  // main sequence
  initial begin
    rst(1'b0);
    rnd(1'b0, 1'b1);
    settle();
    chk("pd0_oe", pins[3].oe[0], periph.reset_drive);
    chk("rst_req", sense.ext_reset_req, !pin_in[3][0]);
    chk("led_on", led_on, 8'h00);
    chk("unlock", dbg_unlocked, 1'b0);
    chk("pa_oe", pins[0].oe, gpio_oe[0]);
    chk("pa_o", pins[0].o, gpio_o[0]);
    rsub(3, `PM_SUB_ALT, `PM_RST_ALT_PD);
    xfer(1'b0, `PM_OFS_STAT, 8'h00);
    xfer(1'b0, `PM_OFS_LVLH, 8'h00);
    xfer(1'b0, 8'h40, 8'h00);
    wsub(3, `PM_SUB_ALT, 8'h00);
    wsub(0, `PM_SUB_ALT, 8'hFF);
    wsub(0, `PM_SUB_FSHI, 8'hFF);
    rsub(0, `PM_SUB_FSHI, 8'h00);
    // both timer modes on the shared timer pins
    for (int m = 0; m < 2; m++) begin
      rnd(!m[0], m[0]);
      settle();
      chk("pd0_oe", pins[3].oe[0], 1'b1);
      chk("pd0_o", pins[3].o[0], gpio_o[3][0]);
      chk("pa_oe", pins[0].oe, {1'b1, !m[0], 4'b1001, 1'b1, m[0]});
      chk("pa_o", {pins[0].o[7], pins[0].o[5], pins[0].o[2:1]},
          {periph.t1_out, periph.ser_txd, periph.ser_de, periph.t0_out});
      chk("ser_in", {sense.ser_rxd, sense.ser_cts}, pin_in[0][4:3]);
      chk("t0_pin", m ? pins[0].o[0] : sense.t0_in,
          m ? periph.t0_outc : pin_in[0][0]);
      chk("t1_pin", m ? sense.t1_in : pins[0].o[6],
          m ? pin_in[0][6] : periph.t1_outc);
    end
    @(posedge hclk);
    xtal_enable <= 1'b1;
    settle();
    chk("xtal", {pins[0].oe[1:0], pins[0].o[1:0]}, 4'h0);
    xfer(1'b0, `PM_OFS_STAT, 8'h04);
    // clock enable low must freeze the pads despite the crystal dropping
    ce          <= 1'b0;
    xtal_enable <= 1'b0;
    settle();
    chk("ce_hold", {pins[0].oe[1:0], pins[0].o[1:0]}, 4'h0);
    @(posedge hclk);
    ce          <= 1'b1;
    wsub(1, `PM_SUB_FSLO, 8'hFF);
    wsub(1, `PM_SUB_ALT, 8'hFF);
    settle();
    chk("anlg_b", analog_sel[1], 8'h3F);
    wsub(1, `PM_SUB_FSLO, 8'hF6);
    settle();
    chk("anlg_b", analog_sel[1], 8'h36);
    chk("ext_clk", sense.ext_clk, pin_in[1][3]);
    chk("pb_oe", pins[1].oe, 8'h00);
    rsub(1, `PM_SUB_FSLO, 8'hF6);
    wsub(2, `PM_SUB_FSLO, 8'hF7);
    wsub(2, `PM_SUB_ALT, 8'hFF);
    xfer(1'b1, `PM_OFS_LED_DRIVER_ENABLE, 8'hFF);
    // random sink levels per pin, one xorshift draw in each of four rounds
    for (int k = 0; k < 4; k++) begin
      rs = xs(rs);
      xfer(1'b1, `PM_OFS_LVLH, rs[7:0]);
      xfer(1'b1, `PM_OFS_LVLL, rs[15:8]);
      settle();
      for (int i = 0; i < 8; i++)
        lv[i] = {rs[i], rs[8 + i]};
      chk("led_lvl", led_level, lv);
      chk("led_on", led_on, 8'hF7);
      chk("cmp_pin", {pins[2].oe[3], pins[2].o[3]},
          {1'b1, periph.comp_out});
      xfer(1'b0, `PM_OFS_LVLL, rs[15:8]);
    end
    xfer(1'b1, `PM_OFS_LED_DRIVER_ENABLE, 8'h00);
    settle();
    chk("led_on", led_on, 8'h00);
    // small package: shared reset and debug pins
    small_pkg <= 1'b1;
    rst(1'b0);
    rnd(1'b0, 1'b0);
    settle();
    chk("unlock", dbg_unlocked, 1'b0);
    chk("pa2_oe", pins[0].oe[2], periph.reset_drive);
    chk("rst_req", sense.ext_reset_req, !pin_in[0][2]);
    rsub(0, `PM_SUB_FSHI, `PM_RST_PA2);
    wsub(0, `PM_SUB_ALT, 8'h00);
    settle();
    chk("pa_oe", pins[0].oe, gpio_oe[0]);
    rst(1'b1);
    rnd(1'b0, 1'b0);
    settle();
    chk("unlock", dbg_unlocked, 1'b1);
    chk("dbg_pin", {pins[0].oe[0], pins[0].o[0]},
        {periph.dbg_oe, periph.dbg_o});
    rsub(0, `PM_SUB_ALT, `PM_RST_PA2);
    xfer(1'b0, `PM_OFS_STAT, 8'h03);
    wsub(0, `PM_SUB_FSLO, 8'h12);
    wsub(0, `PM_SUB_FSHI, 8'h20);
    wsub(0, `PM_SUB_ALT, 8'h3E);
    settle();
    chk("ext_clk", sense.ext_clk, pin_in[0][1]);
    chk("pa_oe_s", pins[0].oe[5:1], 5'b10010);
    chk("pa_o_s", {pins[0].o[5], pins[0].o[2]},
        {periph.t1_outc, periph.ser_de});
    chk("cts", sense.ser_cts, pin_in[0][3]);
    conclude();
  end
endmodule
